// *** core/ldo_cfg_defines.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef LDO_CFG_DEFINES_SVH
`define LDO_CFG_DEFINES_SVH

`define ADDR_LDO1_VOLTAGE_SETTING 8'h71
`define ADDR_LDO1_SEQ 8'h72
`define ADDR_LDO1_RSTDB 8'h73
`define ADDR_LDO1_DLYREF 8'h74
`define ADDR_CONV_ILIM 8'h79
`define ADDR_LIN_ILIM 8'h7a
`define ADDR_BURST 8'h7b
`define ADDR_FREQ 8'h7c

`define RST_LDO1_VOLTAGE_SETTING 8'h28
`define RST_LDO1_SEQ 8'h61
`define RST_LDO1_RSTDB 8'h80
`define RST_LDO1_DLYREF 8'h10
`define RST_CONV_ILIM 8'h6a
`define RST_LIN_ILIM 8'he8
`define RST_BURST 8'h0f
`define RST_FREQ 8'hf0

// Write masks: zero bits are read-only
`define WMASK_SEQ 8'hfb
`define WMASK_RSTDB 8'hbf
`define WMASK_ALL 8'hff

// Field positions
`define SEQ_LATCH_BIT 5
`define SEQ_SLEEP_BIT 4
`define SEQ_POK_PIN_BIT 3
`define SEQ_CONV2_REF_BIT 2
`define RSTDB_AUX_BIT 6
`define DLY_CONV1_REF_BIT 0
`define LIN_PUSH_PULL_BIT 0

// Turn-on delay: times in ns, cycles at 8 ns clock period
`define CLK_PERIOD_NS 8
`define DLY_BASE_NS 41000
`define DLY_FIRST_NS 113000
`define DLY_STEP_NS 100000
`define DLY_BASE_CYC (`DLY_BASE_NS / `CLK_PERIOD_NS)
`define DLY_FIRST_CYC (`DLY_FIRST_NS / `CLK_PERIOD_NS)
`define DLY_STEP_CYC (`DLY_STEP_NS / `CLK_PERIOD_NS)
`define DLY_CNT_W 17

`endif

// *** core/ldo_cfg_pkg.sv ***
// Types shared by the regulator configuration bank
package ldo_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {OFF_ST, DELAY_ST, ON_ST} ldo_state_e;
endpackage

// *** core/cfg_byte_reg.sv ***
// One byte-wide configuration register with per-bit write mask
`include "ldo_cfg_defines.svh"
module cfg_byte_reg
  import ldo_cfg_pkg::*;
#(
  parameter byte_t RESET_VAL = 8'h00,
  parameter byte_t WMASK = 8'hff
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic we,
  input wire byte_t wdata,
  output byte_t value
);
  typedef struct packed {byte_t value;} st_s;
  st_s st;
  st_s next_st;

  always_comb begin
    next_st = st;
    if (we) begin
      // Read-only bits keep their stored value
      next_st.value = (wdata & WMASK) | (st.value & ~WMASK); // RL21
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st.value <= RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;
endmodule

// *** core/turn_on_timer.sv ***
// Turn-on delay counter for the first linear regulator
`include "ldo_cfg_defines.svh"
module turn_on_timer
  import ldo_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic trigger,
  input wire logic [2:0] code,
  output logic expired
);
  typedef struct packed {
    logic [`DLY_CNT_W-1:0] count;
    logic running;
    logic done;
  } st_s;
  st_s st;
  st_s next_st;
  logic [`DLY_CNT_W-1:0] target;

  // 000 is 41 us, 001 is 113 us, then 100 us steps
  always_comb begin
    if (code == 3'h0) begin
      target = `DLY_CNT_W'(`DLY_BASE_CYC);
    end else begin
      target = `DLY_CNT_W'(`DLY_FIRST_CYC + (32'(code) - 32'h1) *
        `DLY_STEP_CYC); // RL8
    end
  end

  always_comb begin
    next_st = st;
    if (!trigger) begin
      next_st.count = '0;
      next_st.running = 1'b0;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      next_st.running = 1'b1;
      next_st.count = st.count + `DLY_CNT_W'(1);
      if (st.count + `DLY_CNT_W'(1) >= target) begin
        next_st.done = 1'b1; // RL22
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.done;
endmodule

// *** core/ldo_and_limit_config_regs.sv ***
// Configuration bank for the first linear regulator and shared limits
//
// Function
// [RL1] Voltage code bits 6:0 sets target 2.0 V plus 25 mV per step.
// [RL2] Latch bit 0 turns regulator off when its sequencing input drops.
// [RL3] Sleep bit 1 turns regulator off in sleep.
// [RL4] Pin-drive bit 1 lets power-ok drive the external enable pin.
// [RL5] Read-only bit selects second converter reference 0.6 or 0.8 V.
// [RL6] Two-bit soft-start code selects ramp time; code 00 limited.
// [RL7] Read-only aux link bit pulls aux reset low on turn-off.
// [RL8] Three-bit turn-on delay: 41, 113, then 100 us steps to 713.
// [RL9] Writable bit 0 selects first converter reference 0.6 or 0.8 V.
// [RL10] Host leaves factory sequencing fields unchanged.
// [RL11] Host preserves reserved bits on writes.
// [RL12] First converter peak limit code in bits 7:6.
// [RL13] Converters two to four peak limit codes, 2 bits each.
// [RL14] Linear limit register bits 7:2 hold three limit fields.
// [RL15] Second and third linear regulator limit codes.
// [RL16] Bit 0 of linear limit register makes enable pin push-pull.
// [RL17] Burst bits 7:4 keep low-side switch off in burst.
// [RL18] Burst bits 3:0 select deep low-power burst, reset to 1.
// [RL19] Frequency bits 7:4 halve converter switching frequency.
// [RL20] Frequency bits 3:0 disable converter low-power mode.
// [RL21] Read-only fields ignore writes; reads return all bits.
// [RL22] Turn-on delay counted from clock, starting at trigger.
`include "ldo_cfg_defines.svh"
module ldo_and_limit_config_regs
  import ldo_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire byte_t REG_ADDR,
  input wire byte_t REG_WDATA,
  output byte_t REG_RDATA,
  output logic REG_HIT,
  input wire logic SEQ_INPUT_ON,
  input wire logic SLEEP_MODE,
  input wire logic LDO1_POWER_OK,
  output logic LDO1_ENABLE,
  output logic [6:0] VOLTAGE_CODE,
  output logic [1:0] SOFT_START_CODE,
  output logic CONV1_HIGH_REFERENCE,
  output logic CONV2_HIGH_REFERENCE,
  output logic AUX_RESET_OUTPUT_N,
  output logic EXTERNAL_ENABLE_PIN_OUT,
  output logic EXTERNAL_ENABLE_PIN_OE_N,
  output logic [1:0] CONV1_PEAK_LIMIT,
  output logic [1:0] CONV2_PEAK_LIMIT,
  output logic [1:0] CONV3_PEAK_LIMIT,
  output logic [1:0] CONV4_PEAK_LIMIT,
  output logic [1:0] LINEAR1_CURRENT_LIMIT,
  output logic [1:0] LINEAR2_CURRENT_LIMIT,
  output logic [1:0] LINEAR3_CURRENT_LIMIT,
  output logic [3:0] CONV_BURST_ASYNC,
  output logic [3:0] CONV_DEEP_BURST,
  output logic [3:0] CONV_HALF_SWITCHING,
  output logic [3:0] CONV_LOWPOWER_OFF
);

  ////////////////////////////////////////////////////////////////////////
  // Register file

  byte_t r_vset;
  byte_t r_seq;
  byte_t r_rstdb;
  byte_t r_dly;
  byte_t r_cilim;
  byte_t r_lilim;
  byte_t r_burst;
  byte_t r_freq;

  cfg_byte_reg #(.RESET_VAL(`RST_LDO1_VOLTAGE_SETTING), .WMASK(`WMASK_ALL)) u_vset (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_LDO1_VOLTAGE_SETTING),
    .wdata(REG_WDATA), .value(r_vset));
  // Reference select bit is factory-set and read-only
  cfg_byte_reg #(.RESET_VAL(`RST_LDO1_SEQ), .WMASK(`WMASK_SEQ)) u_seq (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_LDO1_SEQ),
    .wdata(REG_WDATA), .value(r_seq)); // RL5
  cfg_byte_reg #(.RESET_VAL(`RST_LDO1_RSTDB), .WMASK(`WMASK_RSTDB)) u_rstdb (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_LDO1_RSTDB),
    .wdata(REG_WDATA), .value(r_rstdb)); // RL7
  cfg_byte_reg #(.RESET_VAL(`RST_LDO1_DLYREF), .WMASK(`WMASK_ALL)) u_dly (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_LDO1_DLYREF),
    .wdata(REG_WDATA), .value(r_dly));
  cfg_byte_reg #(.RESET_VAL(`RST_CONV_ILIM), .WMASK(`WMASK_ALL)) u_cilim (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_CONV_ILIM),
    .wdata(REG_WDATA), .value(r_cilim));
  cfg_byte_reg #(.RESET_VAL(`RST_LIN_ILIM), .WMASK(`WMASK_ALL)) u_lilim (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_LIN_ILIM),
    .wdata(REG_WDATA), .value(r_lilim));
  cfg_byte_reg #(.RESET_VAL(`RST_BURST), .WMASK(`WMASK_ALL)) u_burst (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_BURST),
    .wdata(REG_WDATA), .value(r_burst)); // RL18
  cfg_byte_reg #(.RESET_VAL(`RST_FREQ), .WMASK(`WMASK_ALL)) u_freq (
    .CLK(CLK), .RESET(RESET),
    .we(REG_WR && REG_ADDR == `ADDR_FREQ),
    .wdata(REG_WDATA), .value(r_freq));

  ////////////////////////////////////////////////////////////////////////
  // Regulator sequencing state

  typedef struct packed {
    ldo_state_e state;
    byte_t rdata;
    logic hit;
    logic aux_n;
    logic pin_level;
    logic [`DLY_CNT_W-1:0] dwell;
  } st_s;
  st_s st;
  st_s next_st;
  logic delay_done;
  logic trigger;
  logic sleep_off;

  assign sleep_off = SLEEP_MODE && r_seq[`SEQ_SLEEP_BIT]; // RL3
  // Trigger held while input on, or latched once on, unless sleep with the sleep bit set forces it low
  assign trigger = (SEQ_INPUT_ON ||
    (r_seq[`SEQ_LATCH_BIT] && st.state == ON_ST)) && !sleep_off; // RL2

  turn_on_timer u_timer (
    .CLK(CLK),
    .RESET(RESET),
    .trigger(trigger && st.state != ON_ST),
    .code(r_dly[3:1]),
    .expired(delay_done)
  );

  always_comb begin
    next_st = st;
    next_st.hit = 1'b0;
    case (st.state)
      OFF_ST: begin
        if (trigger) begin
          next_st.state = DELAY_ST;
        end
      end
      DELAY_ST: begin
        if (!trigger) begin
          next_st.state = OFF_ST;
        end else if (delay_done) begin
          next_st.state = ON_ST; // RL22
        end
      end
      ON_ST: begin
        if (!trigger) begin
          next_st.state = OFF_ST; // RL2
        end
      end
      default: begin
        next_st.state = OFF_ST;
      end
    endcase
    // Cycles spent waiting; only the delay checks read it
    if (next_st.state == DELAY_ST) begin
      next_st.dwell = st.dwell + `DLY_CNT_W'(1);
    end else begin
      next_st.dwell = '0;
    end
    // Aux reset pulled low on turn-off when linked; released on turn-on
    if (st.state == ON_ST && next_st.state == OFF_ST &&
        r_rstdb[`RSTDB_AUX_BIT]) begin
      next_st.aux_n = 1'b0; // RL7
    end else if (next_st.state == ON_ST) begin
      next_st.aux_n = 1'b1;
    end
    next_st.pin_level = r_seq[`SEQ_POK_PIN_BIT] && LDO1_POWER_OK; // RL4
    if (REG_RD) begin
      next_st.hit = 1'b1;
      case (REG_ADDR)
        `ADDR_LDO1_VOLTAGE_SETTING: next_st.rdata = r_vset; // RL21
        `ADDR_LDO1_SEQ: next_st.rdata = r_seq;
        `ADDR_LDO1_RSTDB: next_st.rdata = r_rstdb;
        `ADDR_LDO1_DLYREF: next_st.rdata = r_dly;
        `ADDR_CONV_ILIM: next_st.rdata = r_cilim;
        `ADDR_LIN_ILIM: next_st.rdata = r_lilim;
        `ADDR_BURST: next_st.rdata = r_burst;
        `ADDR_FREQ: next_st.rdata = r_freq;
        default: begin
          // Other banks answer for their own addresses
          next_st.rdata = 8'h00;
          next_st.hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st.state <= OFF_ST;
      st.rdata <= 8'h00;
      st.hit <= 1'b0;
      st.aux_n <= 1'b1;
      st.pin_level <= 1'b0;
      st.dwell <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the analog blocks

  assign REG_RDATA = st.rdata;
  assign REG_HIT = st.hit;
  assign LDO1_ENABLE = (st.state == ON_ST);
  assign VOLTAGE_CODE = r_vset[6:0]; // RL1
  // Code 00 at 2.5/3.3 V is the host's to avoid; passed through as is
  assign SOFT_START_CODE = r_seq[1:0]; // RL6
  assign CONV2_HIGH_REFERENCE = r_seq[`SEQ_CONV2_REF_BIT]; // RL5
  assign CONV1_HIGH_REFERENCE = r_dly[`DLY_CONV1_REF_BIT]; // RL9
  assign AUX_RESET_OUTPUT_N = st.aux_n;
  // Open-drain unless push-pull: only the low level is driven then
  assign EXTERNAL_ENABLE_PIN_OUT = st.pin_level;
  assign EXTERNAL_ENABLE_PIN_OE_N = !(r_lilim[`LIN_PUSH_PULL_BIT] ||
    !st.pin_level); // RL16
  assign CONV1_PEAK_LIMIT = r_cilim[7:6]; // RL12
  assign CONV2_PEAK_LIMIT = r_cilim[5:4]; // RL13
  assign CONV3_PEAK_LIMIT = r_cilim[3:2];
  assign CONV4_PEAK_LIMIT = r_cilim[1:0];
  assign LINEAR1_CURRENT_LIMIT = r_lilim[7:6]; // RL14
  assign LINEAR2_CURRENT_LIMIT = r_lilim[5:4]; // RL15
  assign LINEAR3_CURRENT_LIMIT = r_lilim[3:2];
  assign CONV_BURST_ASYNC = r_burst[7:4]; // RL17
  assign CONV_DEEP_BURST = r_burst[3:0]; // RL18
  assign CONV_HALF_SWITCHING = r_freq[7:4]; // RL19
  assign CONV_LOWPOWER_OFF = r_freq[3:0]; // RL20

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_on_then_drop;
    st.state == ON_ST ##1 !SEQ_INPUT_ON && !r_seq[`SEQ_LATCH_BIT];
  endsequence

  a_drop_turns_off: assert property (@(posedge CLK) disable iff (RESET)
    s_on_then_drop |=> !LDO1_ENABLE) // RL2
    else $error("regulator stayed on after input dropped");
  a_latch_holds_on: assert property (@(posedge CLK) disable iff (RESET)
    LDO1_ENABLE && r_seq[`SEQ_LATCH_BIT] && !sleep_off |=> LDO1_ENABLE) // RL2
    else $error("latched regulator turned off");
  a_sleep_forces_off: assert property (@(posedge CLK) disable iff (RESET)
    sleep_off |=> !LDO1_ENABLE) // RL3
    else $error("regulator on in sleep");
  a_pin_follows_pok: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> EXTERNAL_ENABLE_PIN_OUT ==
      $past(r_seq[`SEQ_POK_PIN_BIT] && LDO1_POWER_OK)) // RL4
    else $error("enable pin does not follow power ok");
  a_ro_ref_kept: assert property (@(posedge CLK) disable iff (RESET) // RL5
    REG_WR && REG_ADDR == `ADDR_LDO1_SEQ |=> $stable(CONV2_HIGH_REFERENCE))
    else $error("read-only reference bit changed");
  a_aux_low_off: assert property (@(posedge CLK) disable iff (RESET)
    $fell(LDO1_ENABLE) && $past(r_rstdb[`RSTDB_AUX_BIT]) |->
      !AUX_RESET_OUTPUT_N) // RL7
    else $error("aux reset not asserted on turn-off");
  a_no_early_on: assert property (@(posedge CLK) disable iff (RESET)
    $rose(st.state == DELAY_ST) |-> ##1 !LDO1_ENABLE [*8]) // RL22
    else $error("regulator on before delay");
  // Long waits are counted in dwell rather than unrolled as repetitions
  a_delay_zero: assert property (@(posedge CLK) disable iff (RESET) // RL8
    st.state == DELAY_ST && r_dly[3:1] == 3'h0 |->
      st.dwell <= `DLY_CNT_W'(`DLY_BASE_CYC))
    else $error("shortest delay overrun");
  a_delay_min: assert property (@(posedge CLK) disable iff (RESET) // RL8
    $rose(LDO1_ENABLE) && r_dly[3:1] == 3'h0 |->
      $past(st.dwell) >= `DLY_CNT_W'(`DLY_BASE_CYC))
    else $error("shortest delay cut short");
  a_push_pull_drive: assert property (@(posedge CLK) disable iff (RESET)
    r_lilim[`LIN_PUSH_PULL_BIT] |-> !EXTERNAL_ENABLE_PIN_OE_N) // RL16
    else $error("push-pull pin not driven");
  a_read_hit: assert property (@(posedge CLK) disable iff (RESET)
    REG_RD && REG_ADDR == `ADDR_FREQ |=> REG_HIT &&
      REG_RDATA == $past(r_freq)) // RL21
    else $error("read data wrong");

  // Register writes reach the analog fields one cycle later
  a_vcode_write: assert property (@(posedge CLK) disable iff (RESET) // RL1
    REG_WR && REG_ADDR == `ADDR_LDO1_VOLTAGE_SETTING |=>
      VOLTAGE_CODE == $past(REG_WDATA[6:0]))
    else $error("voltage code not written");
  a_ss_write: assert property (@(posedge CLK) disable iff (RESET) // RL6
    REG_WR && REG_ADDR == `ADDR_LDO1_SEQ |=>
      SOFT_START_CODE == $past(REG_WDATA[1:0]))
    else $error("soft-start code not written");
  a_aux_ro_kept: assert property (@(posedge CLK) disable iff (RESET) // RL7
    REG_WR && REG_ADDR == `ADDR_LDO1_RSTDB |=>
      $stable(r_rstdb[`RSTDB_AUX_BIT]))
    else $error("read-only aux link bit changed");
  a_ref1_write: assert property (@(posedge CLK) disable iff (RESET) // RL9
    REG_WR && REG_ADDR == `ADDR_LDO1_DLYREF |=>
      CONV1_HIGH_REFERENCE == $past(REG_WDATA[`DLY_CONV1_REF_BIT]))
    else $error("first converter reference not written");
  a_peak_write: assert property (@(posedge CLK) disable iff (RESET) // RL12
    REG_WR && REG_ADDR == `ADDR_CONV_ILIM |=>
      {CONV1_PEAK_LIMIT, CONV2_PEAK_LIMIT, CONV3_PEAK_LIMIT,
      CONV4_PEAK_LIMIT} == $past(REG_WDATA))
    else $error("peak limits not written");
  a_lin_write: assert property (@(posedge CLK) disable iff (RESET) // RL14
    REG_WR && REG_ADDR == `ADDR_LIN_ILIM |=>
      {LINEAR1_CURRENT_LIMIT, LINEAR2_CURRENT_LIMIT,
      LINEAR3_CURRENT_LIMIT} == $past(REG_WDATA[7:2]))
    else $error("linear limits not written");
  a_rsvd_write: assert property (@(posedge CLK) disable iff (RESET) // RL21
    REG_WR && REG_ADDR == `ADDR_LIN_ILIM |=>
      r_lilim[1] == $past(REG_WDATA[1]))
    else $error("reserved bit not stored");
  a_burst_write: assert property (@(posedge CLK) disable iff (RESET) // RL17
    REG_WR && REG_ADDR == `ADDR_BURST |=>
      {CONV_BURST_ASYNC, CONV_DEEP_BURST} == $past(REG_WDATA))
    else $error("burst fields not written");
  a_freq_write: assert property (@(posedge CLK) disable iff (RESET) // RL19
    REG_WR && REG_ADDR == `ADDR_FREQ |=>
      {CONV_HALF_SWITCHING, CONV_LOWPOWER_OFF} == $past(REG_WDATA))
    else $error("frequency fields not written");

  // Reset values seen at the first edge after release
  a_burst_reset: assert property (@(posedge CLK) disable iff (RESET) // RL18
    $past(RESET) |-> r_burst == `RST_BURST && r_vset == `RST_LDO1_VOLTAGE_SETTING)
    else $error("reset value wrong");

  // Read port
  a_read_vset: assert property (@(posedge CLK) disable iff (RESET) // RL21
    REG_RD && REG_ADDR == `ADDR_LDO1_VOLTAGE_SETTING |=> REG_HIT &&
      REG_RDATA == $past(r_vset))
    else $error("voltage register read wrong");
  a_read_seq: assert property (@(posedge CLK) disable iff (RESET) // RL21
    REG_RD && REG_ADDR == `ADDR_LDO1_SEQ |=> REG_HIT &&
      REG_RDATA == $past(r_seq))
    else $error("sequencing register read wrong");
  a_read_miss: assert property (@(posedge CLK) disable iff (RESET) // RL21
    REG_RD && !(REG_ADDR inside {`ADDR_LDO1_VOLTAGE_SETTING, `ADDR_LDO1_SEQ,
      `ADDR_LDO1_RSTDB, `ADDR_LDO1_DLYREF, `ADDR_CONV_ILIM,
      `ADDR_LIN_ILIM, `ADDR_BURST, `ADDR_FREQ}) |=>
      !REG_HIT && REG_RDATA == 8'h00)
    else $error("unmapped address answered");
  a_hit_needs_rd: assert property (@(posedge CLK) disable iff (RESET) // RL21
    !$past(REG_RD) |-> !REG_HIT)
    else $error("hit without read");

  // Sequencing and pins
  a_on_has_trig: assert property (@(posedge CLK) disable iff (RESET) // RL22
    LDO1_ENABLE |-> $past(trigger))
    else $error("regulator on without trigger");
  a_on_after_dly: assert property (@(posedge CLK) disable iff (RESET) // RL22
    $rose(LDO1_ENABLE) |-> $past(delay_done))
    else $error("regulator on before timer expired");
  a_aux_release: assert property (@(posedge CLK) disable iff (RESET) // RL7
    $rose(LDO1_ENABLE) |-> AUX_RESET_OUTPUT_N)
    else $error("aux reset held on turn-on");
  a_open_drain: assert property (@(posedge CLK) disable iff (RESET) // RL16
    !r_lilim[`LIN_PUSH_PULL_BIT] && EXTERNAL_ENABLE_PIN_OUT |->
      EXTERNAL_ENABLE_PIN_OE_N)
    else $error("open-drain pin drove high");
endmodule

// *** bench/host_model.sv ***
// Host side of the strobed byte register port
module host_model
  import ldo_cfg_pkg::*;
(
  input wire logic clk,
  output logic wr,
  output logic rd,
  output byte_t addr,
  output byte_t wdata,
  input wire byte_t rdata,
  input wire logic hit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  ////////////////////////////////////////
  // Released bus shows the inverse address; only wr_reg also inverts wdata, rd_reg leaves it as it was
  task automatic wr_reg(input byte_t a, input byte_t v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask
  task automatic rd_reg(input byte_t a, output byte_t v, output logic h);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    v = rdata;
    h = hit;
  endtask
  // Touches only the bits in m, so reserved and factory bits survive
  task automatic rmw(input byte_t a, input byte_t m, input byte_t v);
    byte_t cur;
    logic h;
    rd_reg(a, cur, h);
    wr_reg(a, (cur & ~m) | (v & m));
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the regulator configuration bank
`include "ldo_cfg_defines.svh"
module testbench
  import ldo_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, wr, rd, hit, seq_on, sleep, power_ok, en, c1ref, c2ref;
  logic aux_n, pin, pin_oe_n, h;
  byte_t addr, wdata, rdata, d, p;
  logic [6:0] vcode;
  logic [1:0] ss, pl1, pl2, pl3, pl4, ll1, ll2, ll3;
  logic [3:0] basync, bdeep, bhalf, blpoff;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  byte_t ra [8] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h79, 8'h7a, 8'h7b, 8'h7c};
  byte_t rv [8] = '{8'h28, 8'h61, 8'h80, 8'h10, 8'h6a, 8'he8, 8'h0f, 8'hf0};
  // Bit 2 of 0x72 and bit 6 of 0x73 ignore writes
  byte_t wm [8] = '{8'hff, 8'hfb, 8'hbf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ldo_and_limit_config_regs dut (
    .CLK(clk), .RESET(reset), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit),
    .SEQ_INPUT_ON(seq_on), .SLEEP_MODE(sleep), .LDO1_POWER_OK(power_ok),
    .LDO1_ENABLE(en), .VOLTAGE_CODE(vcode), .SOFT_START_CODE(ss),
    .CONV1_HIGH_REFERENCE(c1ref), .CONV2_HIGH_REFERENCE(c2ref),
    .AUX_RESET_OUTPUT_N(aux_n), .EXTERNAL_ENABLE_PIN_OUT(pin),
    .EXTERNAL_ENABLE_PIN_OE_N(pin_oe_n),
    .CONV1_PEAK_LIMIT(pl1), .CONV2_PEAK_LIMIT(pl2),
    .CONV3_PEAK_LIMIT(pl3), .CONV4_PEAK_LIMIT(pl4),
    .LINEAR1_CURRENT_LIMIT(ll1), .LINEAR2_CURRENT_LIMIT(ll2),
    .LINEAR3_CURRENT_LIMIT(ll3), .CONV_BURST_ASYNC(basync),
    .CONV_DEEP_BURST(bdeep), .CONV_HALF_SWITCHING(bhalf),
    .CONV_LOWPOWER_OFF(blpoff)
  );

  host_model host (
    .clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .hit(hit)
  );

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded wait on the regulator enable; n counts edges waited
  task automatic wait_en(input logic lvl, input int lim);
    n = 0;
    while (en !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (en !== lvl) begin
      n_mismatch++;
      results();
    end
  endtask

  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    seq_on = 1'b0;
    sleep = 1'b0;
    power_ok = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.rd_reg(ra[i], d, h);
      chk({h, d}, {1'b1, rv[i]});
    end
    host.wr_reg(8'h75, 8'hff);
    host.rd_reg(8'h75, d, h);
    chk({h, d}, 9'h000);
    // Defaults: latch on, stay on in sleep, shortest turn-on delay
    @(posedge clk) seq_on <= 1'b1;
    wait_en(1'b1, 6000);
    chk(n >= `DLY_BASE_CYC && n <= `DLY_BASE_CYC + 4, 1'b1);
    @(posedge clk) seq_on <= 1'b0;
    tick(4);
    chk(en, 1'b1);
    @(posedge clk) sleep <= 1'b1;
    tick(4);
    chk(en, 1'b1);
    host.rmw(8'h72, 8'h10, 8'h10);
    wait_en(1'b0, 8);
    chk(aux_n, 1'b1);
    @(posedge clk) sleep <= 1'b0;
    host.rmw(8'h72, 8'h20, 8'h00);
    host.rmw(8'h74, 8'h0e, 8'h02);
    // A dropped trigger mid-delay must restart the count
    @(posedge clk) seq_on <= 1'b1;
    tick(3000);
    chk(en, 1'b0);
    @(posedge clk) seq_on <= 1'b0;
    tick(2);
    @(posedge clk) seq_on <= 1'b1;
    wait_en(1'b1, 16000);
    chk(n >= `DLY_FIRST_CYC && n <= `DLY_FIRST_CYC + 4, 1'b1);
    @(posedge clk) seq_on <= 1'b0;
    wait_en(1'b0, 4);
    chk(aux_n, 1'b1);
    @(posedge clk) power_ok <= 1'b1;
    tick(3);
    chk({pin, pin_oe_n}, 2'b00);
    host.rmw(8'h72, 8'h08, 8'h08);
    tick(3);
    chk({pin, pin_oe_n}, 2'b11);
    host.rmw(8'h7a, 8'h01, 8'h01);
    tick(2);
    chk({pin, pin_oe_n}, 2'b10);
    @(posedge clk) power_ok <= 1'b0;
    tick(3);
    chk(pin, 1'b0);
    // Two opposite patterns catch swapped or stuck field bits
    for (int j = 0; j < 2; j++) begin
      p = j ? 8'h5a : 8'ha5;
      for (int i = 0; i < 8; i++) begin
        host.wr_reg(ra[i], p);
        host.rd_reg(ra[i], d, h);
        chk(d, (rv[i] & ~wm[i]) | (p & wm[i]));
      end
      chk(vcode, p[6:0]);
      chk(ss, p[1:0]);
      chk({c2ref, c1ref}, {1'b0, p[0]});
      chk({pl1, pl2, pl3, pl4}, p);
      chk({ll1, ll2, ll3}, p[7:2]);
      chk({basync, bdeep}, p);
      chk({bhalf, blpoff}, p);
    end
    results();
  end
endmodule
